// ### bench/interlock_checker_properties.sv
// concurrent checks on the interlock engine ports
`timescale 1ns/1ns
module interlock_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins
  input wire logic test_bypass_switch,
  input wire logic [interlock_pkg::NUM_OBJECTS-1:0] cmd_open_pin,
  input wire logic [interlock_pkg::NUM_OBJECTS-1:0] cmd_close_pin,
  input wire logic [interlock_pkg::NUM_OBJECTS-1:0] disconnect_drive_outputs,
  input wire logic [interlock_pkg::NUM_OBJECTS-1:0] connect_drive_outputs,
  input wire logic lock_active_lamp,
  // settings and write handshakes
  input wire logic interlock_use_param,
  input wire logic config_style_param,
  input wire logic mode_wr_en,
  input wire logic mode_wr_val,
  input wire logic mode_select_param,
  input wire logic mode_wr_err,
  input wire logic prog_wr_en,
  input wire logic prog_wr_ok,
  input wire logic prog_wr_err,
  input wire logic cfg_wr_en,
  input wire logic [6:0] cfg_wr_index,
  input wire logic cfg_wr_err
);
  import interlock_pkg::*;
  logic [2:0] age_reg;
  logic [2:0] age_next;
  // cycles since reset, saturating: pipeline checks must not see pre-reset history
  always_comb age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) age_reg <= 3'h0;
    else age_reg <= age_next;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // assertions
  a_lamp_follows_mode: assert property (age_reg != 3'h0 |->
    lock_active_lamp == $past(interlock_use_param && !mode_select_param)) else $error("lamp wrong");
  a_mode_refused: assert property (mode_wr_en && mode_wr_val && !interlock_use_param
    |=> mode_wr_err && !mode_select_param) else $error("mode one not refused");
  a_unused_setting: assert property (!interlock_use_param |=> !mode_select_param)
    else $error("operation mode without interlocks");
  a_prog_answer: assert property (prog_wr_en |=> prog_wr_ok != prog_wr_err)
    else $error("program write answer wrong");
  a_prog_locked: assert property (prog_wr_en && mode_select_param |=> prog_wr_err)
    else $error("program edit in operation mode");
  a_cfg_locked: assert property (cfg_wr_en && (mode_select_param || config_style_param)
    |=> cfg_wr_err) else $error("config change accepted");
  a_cfg_range: assert property (cfg_wr_en && (cfg_wr_index < IND_FIRST ||
    cfg_wr_index > IND_LAST) |=> cfg_wr_err) else $error("indicator range");
  a_drive_needs_cmd: assert property (age_reg > 3'h3 |->
    ((disconnect_drive_outputs & ~$past(cmd_open_pin, 3)) |
    (connect_drive_outputs & ~$past(cmd_close_pin, 3))) == '0) else $error("drive without command");
  a_bypass_passes: assert property (age_reg > 3'h3 && $past(test_bypass_switch, 3) |->
    disconnect_drive_outputs == $past(cmd_open_pin, 3)) else $error("bypass blocked a command");
  c_mode_on: cover property ($rose(mode_select_param));
  c_refused: cover property (mode_wr_err);
  c_drive: cover property (|connect_drive_outputs);
endmodule // interlock_checker
bind interlock_engine interlock_checker interlock_checker_inst (.*);

// ### bench/switchgear_interlock_logic_engine_tb.sv
// self-checking bench for the interlock engine
`timescale 1ns/1ns
module switchgear_interlock_logic_engine_tb;
  import interlock_pkg::*;
  localparam int EVAL_P = 64;
  typedef struct packed {logic [6:0] idx; logic [9:0] d; logic ok; logic [9:0] rd;} row_s;
  logic clk_sys = 1'b0, rst = 1'b1, lr_key_pin = 1'b0, test_bypass_switch = 1'b0;
  logic [6:0] status_open_pin, status_closed_pin, stuck_undef = 7'h00;
  logic [9:0] gen_in_pin = 10'h000;
  logic [5:0] cmd_open_pin = 6'h00, cmd_close_pin = 6'h00;
  logic [5:0] disconnect_drive_outputs, connect_drive_outputs;
  logic interlock_use_param = 1'b0, config_style_param = 1'b0, mode_wr_en = 1'b0;
  logic mode_wr_val = 1'b0, prog_wr_en = 1'b0, cfg_wr_en = 1'b0, lock_active_lamp;
  logic mode_select_param, mode_wr_err, syntax_err, prog_wr_ok, prog_wr_err, cfg_wr_ok, cfg_wr_err;
  logic [11:0] cmd_enables;
  logic [8:0] prog_wr_line = 9'h0c8;
  prog_line_s prog_wr_data = '0;
  logic [6:0] cfg_wr_index = 7'h65, cfg_rd_index = 7'h65;
  ind_cfg_s cfg_wr_data = '0, cfg_rd_data;
  int err_count = 0, comparisons = 0;
  // write/readback table: index, entry, accepted, value read back afterwards
  row_s rows [12] = '{'{7'h65, 10'h268, 1, 10'h268}, '{7'h66, 10'h2ad, 1, 10'h2ad},
    '{7'h67, 10'h270, 0, 0}, '{7'h68, 10'h2ea, 0, 0}, '{7'h69, 10'h2f1, 1, 10'h2f1},
    '{7'h6a, 10'h335, 0, 0}, '{7'h6a, 10'h301, 1, 10'h300}, '{7'h75, 10'h374, 0, 0},
    '{7'h64, 10'h374, 0, 0}, '{7'h6b, 10'h07f, 1, 0}, '{7'h6c, 10'h234, 0, 0},
    '{7'h6c, 10'h366, 0, 0}};
  prog_line_s pg [16] = '{'{fetch_op, 8'h3d}, '{store_op, 8'h14}, '{fetch_op, 8'h3c},
    '{disjunction_negated_op, 8'h3e}, '{store_op, 8'h15}, '{fetch_inverted_op, 8'hc9},
    '{disjunction_op, 8'h01}, '{disjunction_op, 8'h08}, '{store_op, 8'h46},
    '{fetch_op, 8'h46}, '{conjunction_negated_op, 8'h65}, '{store_op, 8'h16},
    '{fetch_op, 8'h3d}, '{conjunction_op, 8'h66}, '{store_op, 8'h17}, '{end_op, 8'h00}};
  interlock_engine #(.EVAL_CYCLES_P(EVAL_P)) interlock_engine_inst (.*);
  switchgear_model switchgear_model_inst (.clk_sys, .rst, .open_drive(disconnect_drive_outputs),
    .close_drive(connect_drive_outputs), .stuck_undef, .open_pin(status_open_pin),
    .closed_pin(status_closed_pin));
  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;
  // ==========================================================
  // tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic prog_wr(input logic [8:0] ln, input prog_line_s d, input logic ok);
    @(posedge clk_sys);
    prog_wr_en <= 1'b1;
    prog_wr_line <= ln;
    prog_wr_data <= d;
    @(posedge clk_sys);
    prog_wr_en <= 1'b0;
    #1 chk({prog_wr_ok, prog_wr_err}, {ok, ~ok}, "program write");
  endtask
  task automatic cfg_wr(input row_s r);
    @(posedge clk_sys);
    cfg_wr_en <= 1'b1;
    cfg_wr_index <= r.idx;
    cfg_wr_data <= r.d;
    cfg_rd_index <= r.idx;
    @(posedge clk_sys);
    cfg_wr_en <= 1'b0;
    #1 chk({cfg_wr_ok, cfg_wr_err}, {r.ok, ~r.ok}, "config write");
    @(posedge clk_sys);
    #1 chk(cfg_rd_data, r.rd, "config readback");
  endtask
  // mode request; waits for the new mode, or for an error pulse when one is expected
  task automatic mode_req(input logic v, input logic exp_mode, input logic exp_err);
    logic seen;
    seen = 1'b0;
    @(posedge clk_sys);
    mode_wr_en <= 1'b1;
    mode_wr_val <= v;
    @(posedge clk_sys);
    mode_wr_en <= 1'b0;
    for (int n = 0; n <= 300; n++) begin
      #1 seen = seen | syntax_err | mode_wr_err;
      if (exp_err ? seen : (mode_select_param === exp_mode)) break;
      if (n == 300) begin
        err_count++;
        $display("FAIL %0t mode request timed out", $time);
        conclude();
      end
      @(posedge clk_sys);
    end
    chk(mode_select_param, exp_mode, "mode");
    chk(seen, exp_err, "mode error pulse");
  endtask
  // holds commands for the 3-cycle pin path, then compares {close, open} drives
  task automatic cmd_chk(input logic [5:0] o, input logic [5:0] c, input logic [11:0] exp);
    @(posedge clk_sys);
    cmd_open_pin <= o;
    cmd_close_pin <= c;
    repeat (4) @(posedge clk_sys);
    #1 chk({connect_drive_outputs, disconnect_drive_outputs}, exp, "drives");
    @(posedge clk_sys);
    cmd_open_pin <= 6'h00;
    cmd_close_pin <= 6'h00;
    repeat (4) @(posedge clk_sys);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk({mode_select_param, cmd_enables}, 12'h000, "after reset");
    foreach (rows[i]) cfg_wr(rows[i]);
    @(posedge clk_sys) config_style_param <= 1'b1;
    cfg_wr('{7'h6d, 10'h07f, 0, 0});
    @(posedge clk_sys) config_style_param <= 1'b0;
    $display("configuration tests done");
    mode_req(1'b1, 1'b0, 1'b1);
    cmd_chk(6'h01, 6'h00, 12'h001);
    interlock_use_param <= 1'b1;
    cmd_chk(6'h01, 6'h00, 12'h000);
    chk(lock_active_lamp, 1'b1, "lamp in setting mode");
    $display("setting mode tests done");
    foreach (pg[i]) prog_wr(9'h0c8 + 9'(i), pg[i], 1'b1);
    prog_wr(9'h12d, pg[0], 1'b0);
    prog_wr(9'h0c8, '{conjunction_op, 8'h3d}, 1'b1);
    mode_req(1'b1, 1'b0, 1'b1);
    prog_wr(9'h0c8, pg[0], 1'b1);
    @(posedge clk_sys) stuck_undef <= 7'h02;
    mode_req(1'b1, 1'b1, 1'b0);
    prog_wr(9'h0c9, pg[0], 1'b0);
    cfg_wr('{7'h6d, 10'h07f, 0, 0});
    chk(lock_active_lamp, 1'b0, "lamp in operation mode");
    repeat (2 * EVAL_P + 20) @(posedge clk_sys);
    #1 chk(cmd_enables, 12'h00b, "enables pass one");
    @(posedge clk_sys) lr_key_pin <= 1'b1;
    gen_in_pin <= 10'h001;
    stuck_undef <= 7'h00;
    repeat (2 * EVAL_P + 20) @(posedge clk_sys);
    #1 chk(cmd_enables, 12'h005, "enables pass two");
    $display("program tests done");
    cmd_chk(6'h03, 6'h03, 12'h003);
    test_bypass_switch <= 1'b1;
    cmd_chk(6'h00, 6'h03, 12'h0c0);
    test_bypass_switch <= 1'b0;
    $display("gating tests done");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk({mode_select_param, cmd_enables}, 12'h000, "second reset");
    $display("reset test done");
    conclude();
  end
endmodule // switchgear_interlock_logic_engine_tb

// ### bench/switchgear_model.sv
// switchgear model: object positions moved by the gated drive outputs
`timescale 1ns/1ns
module switchgear_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // drives from the block, channels forced undefined by the bench
  input wire logic [5:0] open_drive,
  input wire logic [5:0] close_drive,
  input wire logic [6:0] stuck_undef,
  // status contacts back to the block
  output logic [6:0] open_pin,
  output logic [6:0] closed_pin
);
  logic [6:0] closed_reg;
  logic [6:0] closed_next;
  // a drive moves its object; channel 7 has no drive and stays open
  always_comb begin
    closed_next = closed_reg;
    for (int i = 0; i < 6; i++) begin
      if (close_drive[i]) closed_next[i] = 1'b1;
      if (open_drive[i]) closed_next[i] = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) closed_reg <= 7'h00;
    else closed_reg <= closed_next;
  end
  // a stuck contact shows both sides, which the block reads as undefined
  assign closed_pin = closed_reg | stuck_undef;
  assign open_pin = ~closed_reg | stuck_undef;
endmodule // switchgear_model

// ### hw/interlock_engine.sv
// object configuration checker and cyclic interlock program engine
// ==========================================================
`timescale 1ns/1ns
module interlock_engine #(
  parameter int EVAL_CYCLES_P = interlock_pkg::EVAL_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // object status and general input pins
  input wire logic [interlock_pkg::NUM_CHANNELS-1:0] status_open_pin,
  input wire logic [interlock_pkg::NUM_CHANNELS-1:0] status_closed_pin,
  input wire logic [interlock_pkg::NUM_GEN-1:0] gen_in_pin,
  input wire logic lr_key_pin,
  input wire logic test_bypass_switch,
  // merged open and close commands from buttons, bus and inputs
  input wire logic [interlock_pkg::NUM_OBJECTS-1:0] cmd_open_pin,
  input wire logic [interlock_pkg::NUM_OBJECTS-1:0] cmd_close_pin,
  // gated drives to the switchgear
  output logic [interlock_pkg::NUM_OBJECTS-1:0] disconnect_drive_outputs,
  output logic [interlock_pkg::NUM_OBJECTS-1:0] connect_drive_outputs,
  output logic lock_active_lamp,
  // settings
  input wire logic interlock_use_param,
  input wire logic config_style_param,
  input wire logic mode_wr_en,
  input wire logic mode_wr_val,
  output logic mode_select_param,
  output logic mode_wr_err,
  output logic syntax_err,
  output logic [interlock_pkg::NUM_OUTS-1:0] cmd_enables,
  // program line writes
  input wire logic prog_wr_en,
  input wire logic [8:0] prog_wr_line,
  input wire interlock_pkg::prog_line_s prog_wr_data,
  output logic prog_wr_ok,
  output logic prog_wr_err,
  // indicator configuration writes and reads
  input wire logic cfg_wr_en,
  input wire logic [6:0] cfg_wr_index,
  input wire interlock_pkg::ind_cfg_s cfg_wr_data,
  output logic cfg_wr_ok,
  output logic cfg_wr_err,
  input wire logic [6:0] cfg_rd_index,
  output interlock_pkg::ind_cfg_s cfg_rd_data
);
  import interlock_pkg::*;
  localparam int SYNC_W = 2 * NUM_CHANNELS + NUM_GEN + 2 + 2 * NUM_OBJECTS;
  localparam logic [19:0] EVAL_LAST = 20'(EVAL_CYCLES_P - 1);
  function automatic logic ind_in_range(input logic [6:0] code);
    ind_in_range = (code >= IND_FIRST) && (code <= IND_LAST);
  endfunction
  // ==========================================================
  // pin synchronisers: two flops before any logic looks at them
  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {status_open_pin, status_closed_pin, gen_in_pin, lr_key_pin,
        test_bypass_switch, cmd_open_pin, cmd_close_pin};
      sync2_reg <= sync1_reg;
    end
  end
  logic [NUM_CHANNELS-1:0] st_open, st_closed;
  logic [NUM_GEN-1:0] gen_s;
  logic key_s, bypass_s;
  logic [NUM_OBJECTS-1:0] cmd_open_s, cmd_close_s;
  assign {st_open, st_closed, gen_s, key_s, bypass_s, cmd_open_s, cmd_close_s} = sync2_reg;
  // ==========================================================
  // program store, reset to all end lines
  prog_line_s prog_reg [PROG_LINES], prog_next [PROG_LINES];
  logic prog_ok_next, prog_err_next, prog_ok_reg, prog_err_reg, mode_reg, mode_next;
  eng_state_e state_reg, state_next;
  wire logic [6:0] wr_idx = 7'(prog_wr_line - LINE_FIRST);
  // edits only while in setting mode and not being checked
  always_comb begin
    prog_next = prog_reg;
    prog_ok_next = 1'b0;
    prog_err_next = 1'b0;
    if (prog_wr_en && (mode_reg || state_reg == eng_check ||
        prog_wr_line < LINE_FIRST || prog_wr_line > LINE_LAST)) begin
      prog_err_next = 1'b1;
    end else if (prog_wr_en) begin
      prog_next[wr_idx] = prog_wr_data;
      prog_ok_next = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PROG_LINES; i++) begin
        prog_reg[i] <= '{op: end_op, operand: 8'h00};
      end
      prog_ok_reg <= 1'b0;
      prog_err_reg <= 1'b0;
    end else begin
      prog_reg <= prog_next;
      prog_ok_reg <= prog_ok_next;
      prog_err_reg <= prog_err_next;
    end
  end
  // ==========================================================
  // operand decode
  operand_if lk ();
  logic [NUM_TEMPS-1:0] temps_reg, temps_next;
  logic [6:0] ptr_reg, ptr_next;
  wire prog_line_s cur = prog_reg[ptr_reg];
  assign {lk.operand, lk.closed, lk.opened, lk.gen, lk.key_remote, lk.temps} =
    {cur.operand, st_closed, st_open, gen_s, key_s, temps_reg};
  operand_decode u_dec (.lk(lk));
  // ==========================================================
  // evaluation engine, syntax checker and mode control
  logic [19:0] tick_reg, tick_next;
  logic [NUM_OUTS-1:0] work_reg, work_next, en_reg, en_next;
  logic acc_reg, acc_next, mode_err_next, mode_err_reg, syn_err_next, syn_err_reg;
  logic [7:0] tgt;
  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    acc_next = acc_reg;
    temps_next = temps_reg;
    work_next = work_reg;
    en_next = en_reg;
    mode_next = mode_reg;
    mode_err_next = 1'b0;
    syn_err_next = 1'b0;
    tgt = 8'h00;
    tick_next = (tick_reg == EVAL_LAST) ? 20'h00000 : tick_reg + 20'h00001;
    case (state_reg)
      eng_idle: begin
        if (mode_reg && tick_reg == EVAL_LAST) begin
          work_next = '0;
          ptr_next = 7'h00;
          state_next = eng_run;
        end
      end
      eng_run: begin
        ptr_next = ptr_reg + 7'h01;
        case (cur.op)
          fetch_op: acc_next = lk.value;
          fetch_inverted_op: acc_next = ~lk.value;
          conjunction_op: acc_next = acc_reg & lk.value;
          conjunction_negated_op: acc_next = acc_reg & ~lk.value;
          disjunction_op: acc_next = acc_reg | lk.value;
          disjunction_negated_op: acc_next = acc_reg | ~lk.value;
          store_op: begin // accumulator stays as is after a store
            if (cur.operand >= OUT_FIRST && cur.operand <= OUT_LAST) begin
              tgt = cur.operand - OUT_FIRST;
              work_next[tgt[3:0]] = acc_reg;
            end else if (cur.operand >= TEMP_FIRST && cur.operand <= TEMP_LAST) begin
              tgt = cur.operand - TEMP_FIRST;
              temps_next[tgt[4:0]] = acc_reg;
            end
          end
          default: begin
            en_next = work_reg; // publish at end of pass
            state_next = eng_idle;
          end
        endcase
        if (ptr_reg == LAST_IDX && cur.op != end_op) begin // off the last line: an end
          en_next = work_next;
          state_next = eng_idle;
        end
      end
      eng_check: begin
        ptr_next = ptr_reg + 7'h01;
        if ((ptr_reg == 7'h00 && cur.op != fetch_op && cur.op != fetch_inverted_op) ||
            (cur.op == store_op && !lk.legal_write) ||
            (cur.op != store_op && cur.op != end_op && !lk.legal_read) ||
            (ptr_reg == LAST_IDX && cur.op != end_op)) begin
          syn_err_next = 1'b1; // stay in setting mode
          state_next = eng_idle;
        end else if (cur.op == end_op) begin
          mode_next = 1'b1;
          state_next = eng_idle;
        end
      end
      default: state_next = eng_idle;
    endcase
    if (mode_wr_en && state_reg != eng_check) begin // mode requests
      if (!mode_wr_val) begin
        mode_next = 1'b0;
        state_next = eng_idle;
        en_next = '0;
      end else if (!interlock_use_param) begin
        mode_err_next = 1'b1;
      end else if (!mode_reg) begin
        ptr_next = 7'h00;
        state_next = eng_check;
      end
    end
    if (!interlock_use_param) begin // interlocks off: back to setting mode
      mode_next = 1'b0;
      state_next = eng_idle;
      en_next = '0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= eng_idle;
      ptr_reg <= 7'h00;
      acc_reg <= 1'b0;
      temps_reg <= '0;
      work_reg <= '0;
      en_reg <= '0;
      mode_reg <= 1'b0;
      tick_reg <= 20'h00000;
      mode_err_reg <= 1'b0;
      syn_err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      acc_reg <= acc_next;
      temps_reg <= temps_next;
      work_reg <= work_next;
      en_reg <= en_next;
      mode_reg <= mode_next;
      tick_reg <= tick_next;
      mode_err_reg <= mode_err_next;
      syn_err_reg <= syn_err_next;
    end
  end
  // ==========================================================
  // command gating when the command is present; bypass or no interlocks pass all
  logic [NUM_OBJECTS-1:0] open_drv_next, close_drv_next, open_drv_reg, close_drv_reg;
  logic lamp_next, lamp_reg;
  always_comb begin
    for (int i = 0; i < NUM_OBJECTS; i++) begin
      open_drv_next[i] = cmd_open_s[i] & (bypass_s | ~interlock_use_param |
        (mode_reg & en_reg[2*i]));
      close_drv_next[i] = cmd_close_s[i] & (bypass_s | ~interlock_use_param |
        (mode_reg & en_reg[2*i+1]));
    end
    lamp_next = interlock_use_param & ~mode_reg;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      open_drv_reg <= '0;
      close_drv_reg <= '0;
      lamp_reg <= 1'b0;
    end else begin
      open_drv_reg <= open_drv_next;
      close_drv_reg <= close_drv_next;
      lamp_reg <= lamp_next;
    end
  end
  // ==========================================================
  // indicator configuration table with consistency checks
  ind_cfg_s cfg_reg [NUM_IND], cfg_next [NUM_IND];
  ind_cfg_s rd_next, rd_reg, wr_ent;
  logic cfg_ok_next, cfg_err_next, cfg_ok_reg, cfg_err_reg;
  wire logic [3:0] cw_idx = 4'(cfg_wr_index - IND_FIRST);
  wire logic [3:0] cr_idx = 4'(cfg_rd_index - IND_FIRST);
  always_comb begin
    logic bad;
    logic [2:0] objs, cbs;
    bad = 1'b0;
    objs = 3'h0;
    cbs = 3'h0;
    cfg_next = cfg_reg;
    cfg_ok_next = 1'b0;
    cfg_err_next = 1'b0;
    wr_ent = cfg_wr_data;
    if (wr_ent.out_code == OUT_NONE) wr_ent.is_breaker = 1'b0; // uncontrolled: no type
    if (!wr_ent.in_use) wr_ent = '0;
    for (int i = 0; i < NUM_IND; i++) begin
      if (4'(i) != cw_idx && cfg_reg[i].in_use) begin
        objs = objs + 3'h1;
        if (cfg_reg[i].is_breaker) cbs = cbs + 3'h1;
        if (wr_ent.in_use && cfg_reg[i].channel == wr_ent.channel) bad = 1'b1;
        if (wr_ent.in_use && wr_ent.out_code != OUT_NONE &&
            cfg_reg[i].out_code[4:1] == wr_ent.out_code[4:1]) bad = 1'b1;
      end
    end
    if (wr_ent.in_use) begin
      if (objs >= MAX_OBJECTS) bad = 1'b1;
      if (wr_ent.channel < CH_FIRST[2:0] || wr_ent.channel > CH_LAST[2:0]) bad = 1'b1;
      if (wr_ent.out_code != OUT_NONE && wr_ent.out_code < OUT_CODE_FIRST) bad = 1'b1;
      if (wr_ent.is_breaker && cbs >= MAX_BREAKERS) bad = 1'b1;
    end
    if (cfg_wr_en && (mode_reg || config_style_param || !ind_in_range(cfg_wr_index) || bad)) begin
      cfg_err_next = 1'b1;
    end else if (cfg_wr_en) begin
      cfg_next[cw_idx] = wr_ent;
      cfg_ok_next = 1'b1;
    end
    rd_next = ind_in_range(cfg_rd_index) ? cfg_reg[cr_idx] : '0;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_IND; i++) begin
        cfg_reg[i] <= '0;
      end
      rd_reg <= '0;
      cfg_ok_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rd_reg <= rd_next;
      cfg_ok_reg <= cfg_ok_next;
      cfg_err_reg <= cfg_err_next;
    end
  end
  // ==========================================================
  // outputs, all from flops
  assign {disconnect_drive_outputs, connect_drive_outputs, lock_active_lamp, mode_select_param,
    mode_wr_err, syntax_err, cmd_enables, prog_wr_ok, prog_wr_err, cfg_wr_ok, cfg_wr_err,
    cfg_rd_data} = {open_drv_reg, close_drv_reg, lamp_reg, mode_reg, mode_err_reg, syn_err_reg,
    en_reg, prog_ok_reg, prog_err_reg, cfg_ok_reg, cfg_err_reg, rd_reg};
endmodule // interlock_engine

// ### hw/interlock_pkg.sv
// shared constants and types for the switchgear interlock logic engine
package interlock_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_CHANNELS = 7;
  localparam int NUM_GEN = 10;
  localparam int NUM_TEMPS = 20;
  localparam int NUM_OBJECTS = 6;
  localparam int NUM_OUTS = 12;
  localparam int NUM_IND = 16;
  localparam int PROG_LINES = 101;
  localparam logic [2:0] MAX_OBJECTS = 3'h7;
  localparam logic [2:0] MAX_BREAKERS = 3'h2;
  // ==========================================================
  // indicator code numbers (101..116) and program line numbers (200..300)
  localparam logic [6:0] IND_FIRST = 7'h65;
  localparam logic [6:0] IND_LAST = 7'h74;
  localparam logic [8:0] LINE_FIRST = 9'h0c8;
  localparam logic [8:0] LINE_LAST = 9'h12c;
  localparam logic [6:0] LAST_IDX = 7'h64;
  // ==========================================================
  // operand codes
  localparam logic [7:0] CH_FIRST = 8'h01;     // 1
  localparam logic [7:0] CH_LAST = 8'h07;      // 7
  localparam logic [7:0] UNDEF_FIRST = 8'h65;  // 101
  localparam logic [7:0] UNDEF_LAST = 8'h6b;   // 107
  localparam logic [7:0] OPEN_FIRST = 8'hc9;   // 201
  localparam logic [7:0] OPEN_LAST = 8'hcf;    // 207
  localparam logic [7:0] GEN_FIRST = 8'h08;    // 8
  localparam logic [7:0] GEN_LAST = 8'h11;     // 17
  localparam logic [7:0] OUT_FIRST = 8'h14;    // 20
  localparam logic [7:0] OUT_LAST = 8'h1f;     // 31
  localparam logic [7:0] CONST_ZERO = 8'h3c;   // 60
  localparam logic [7:0] CONST_ONE = 8'h3d;    // 61
  localparam logic [7:0] KEY_REG = 8'h3e;      // 62
  localparam logic [7:0] TEMP_FIRST = 8'h46;   // 70
  localparam logic [7:0] TEMP_LAST = 8'h59;    // 89
  localparam logic [4:0] OUT_NONE = 5'h00;
  localparam logic [4:0] OUT_CODE_FIRST = 5'h14;
  localparam logic [4:0] OUT_CODE_LAST = 5'h1f;
  // ==========================================================
  // timing: one evaluation pass every 20 ms at 50 MHz
  localparam int EVAL_PERIOD_MS = 20;
  localparam int CLK_PERIOD_NS = 20;
  localparam int EVAL_CYCLES = EVAL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // ==========================================================
  // program operations
  typedef enum logic [2:0] {
    fetch_op = 3'h0,
    fetch_inverted_op = 3'h1,
    conjunction_op = 3'h2,
    conjunction_negated_op = 3'h3,
    disjunction_op = 3'h4,
    disjunction_negated_op = 3'h5,
    store_op = 3'h6,
    end_op = 3'h7
  } op_e;
  typedef struct packed {
    op_e op;
    logic [7:0] operand;
  } prog_line_s;
  // one indicator configuration entry
  typedef struct packed {
    logic in_use;
    logic [2:0] channel;
    logic [4:0] out_code;
    logic is_breaker;
  } ind_cfg_s;
  // engine states, gray along idle -> run; idle -> check flips both bits
  typedef enum logic [1:0] {
    eng_idle = 2'h0,
    eng_run = 2'h1,
    eng_check = 2'h3
  } eng_state_e;
endpackage

// ### hw/operand_decode.sv
// combinational decode of program operand codes into a bit value
`timescale 1ns/1ns
module operand_decode (
  // operand lookup
  operand_if.decoder lk
);
  import interlock_pkg::*;

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ==========================================================
  // read decode; undefined means both or neither contact closed
  always_comb begin
    logic [7:0] idx;
    idx = 8'h00;
    lk.value = 1'b0;
    lk.legal_read = 1'b1;
    if (in_range(lk.operand, CH_FIRST, CH_LAST)) begin
      idx = lk.operand - CH_FIRST;
      lk.value = lk.closed[idx[2:0]];
    end else if (in_range(lk.operand, UNDEF_FIRST, UNDEF_LAST)) begin
      idx = lk.operand - UNDEF_FIRST;
      lk.value = lk.closed[idx[2:0]] ~^ lk.opened[idx[2:0]];
    end else if (in_range(lk.operand, OPEN_FIRST, OPEN_LAST)) begin
      idx = lk.operand - OPEN_FIRST;
      lk.value = lk.opened[idx[2:0]];
    end else if (in_range(lk.operand, GEN_FIRST, GEN_LAST)) begin
      idx = lk.operand - GEN_FIRST;
      lk.value = lk.gen[idx[3:0]];
    end else if (lk.operand == CONST_ZERO) begin
      lk.value = 1'b0;
    end else if (lk.operand == CONST_ONE) begin
      lk.value = 1'b1;
    end else if (lk.operand == KEY_REG) begin
      lk.value = lk.key_remote;
    end else if (in_range(lk.operand, TEMP_FIRST, TEMP_LAST)) begin
      idx = lk.operand - TEMP_FIRST;
      lk.value = lk.temps[idx[4:0]];
    end else begin
      lk.legal_read = 1'b0;
    end
  end

  // write targets: control outputs and temporaries only
  assign lk.legal_write = in_range(lk.operand, OUT_FIRST, OUT_LAST) ||
    in_range(lk.operand, TEMP_FIRST, TEMP_LAST);
endmodule // operand_decode

// ### hw/operand_if.sv
// operand lookup channel between the engine and its decoder
`timescale 1ns/1ns
interface operand_if;
  import interlock_pkg::*;
  logic [7:0] operand;
  logic [NUM_CHANNELS-1:0] closed;
  logic [NUM_CHANNELS-1:0] opened;
  logic [NUM_GEN-1:0] gen;
  logic key_remote;
  logic [NUM_TEMPS-1:0] temps;
  logic value;
  logic legal_read;
  logic legal_write;
  modport engine (output operand, closed, opened, gen, key_remote, temps,
    input value, legal_read, legal_write);
  modport decoder (input operand, closed, opened, gen, key_remote, temps,
    output value, legal_read, legal_write);
endinterface
